// [bccf_pkg.sv]
// shared constants and types of the condition flag block
// assumes a 32-bit apb slave and a 16-bit instruction parameter word
package bccf_pkg;

	// register index as printed, byte address is four times the index
	localparam logic [11:0] FLAG_REG_INDEX = 12'h0037;
	localparam logic [11:0] FLAG_REG_ADDR = 12'h00DC;

	// field layout of an update word (host write and flag-update parameter)
	localparam int UPD_SET_LSB = 0;
	localparam int UPD_CLR_LSB = 8;
	localparam int GP_COUNT = 8;

	// flag positions inside the general flag byte
	localparam int LESS_FLAG_POS = 0;
	localparam int EQUAL_FLAG_POS = 1;

	// condition field layout
	localparam int COND_INVERT_POS = 4;

	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] RDATA_RESET = 16'h0000;

	// instruction kinds seen by this block
	typedef enum logic [1:0] {
		OP_OTHER = 2'b00,
		OP_MSG_CMP = 2'b01,
		OP_FRAME_CMP = 2'b10,
		OP_FLAG_UPD = 2'b11
	} bccf_op_t;

	// whole state of the top module
	typedef struct packed {
		logic [7:0] flags;
		logic [15:0] rdata;
		logic ack;
		logic err;
	} bccf_state_t;

	// set bits 7:0, clear bits 15:8, both set means toggle
	function automatic logic [7:0] bccf_apply(input logic [7:0] cur, input logic [15:0] w);
		logic [7:0] s;
		logic [7:0] c;
		s = w[UPD_SET_LSB +: GP_COUNT];
		c = w[UPD_CLR_LSB +: GP_COUNT];
		return (cur & ~(s | c)) | (s & ~c) | (s & c & ~cur);
	endfunction

endpackage

// [bccf_cmp_if.sv]
// carries a compare request and its result between top and comparator
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface bccf_cmp_if;
	logic [15:0] param;
	logic [15:0] counter;
	logic less;
	logic equal;
	modport requester (output param, output counter, input less, input equal);
	modport comparator (input param, input counter, output less, output equal);
endinterface

// [bccf_cmp.sv]
// unsigned comparator of instruction parameter against a timer counter
// assumes the requester holds both operands for the cycle it samples
`timescale 1ns/1ps
module bccf_cmp (
	// compare request and result
	bccf_cmp_if.comparator cmp
);
	// ordering decides the less flag, not a fixed value
	assign cmp.less = cmp.param < cmp.counter;
	assign cmp.equal = cmp.param == cmp.counter;
endmodule

// [bccf_flags.sv]
// general condition flags, condition evaluation and the flag register
// assumes instruction inputs are synchronous to CLK and one cycle per op
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - code one tests equal flag, inverted not-equal
// - message-timer compare sets flag one on equality
// - frame-timer compare sets flag one on equality
// - flag one updated by instruction or host
// - codes two to seven test flags two-seven
// - flags two-seven updated by instruction or host
// - low four bits select, bit four inverts
// - compare sets less flag when parameter below
// - host reads all sixteen codes at index
module bccf_flags #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// instruction execution
	input wire logic OP_EXEC,
	input wire bccf_pkg::bccf_op_t OP_KIND,
	input wire logic [15:0] OP_PARAM,
	input wire logic [4:0] OP_COND,
	// timer counters
	input wire logic [15:0] MSG_TIMER,
	input wire logic [15:0] FRAME_TIMER,
	// message result codes, kept elsewhere
	input wire logic [7:0] MSG_RESULT,
	// condition outcome and flag view
	output logic COND_MET,
	output logic [7:0] GP_FLAGS
);

	////////////////////////////////////////////////////////////////////////
	// state

	bccf_pkg::bccf_state_t s_q;
	bccf_pkg::bccf_state_t s_d;
	bccf_cmp_if cmp_if ();
	logic [15:0] codes;
	logic hit;
	logic wr_done;
	logic rd_done;
	logic is_cmp;

	// comparator sees the counter picked by the instruction kind
	assign cmp_if.param = OP_PARAM;
	assign cmp_if.counter = (OP_KIND == bccf_pkg::OP_FRAME_CMP) ? FRAME_TIMER : MSG_TIMER;

	bccf_cmp u_cmp (
		.cmp(cmp_if.comparator)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	assign codes = {MSG_RESULT, s_q.flags};
	assign hit = PADDR == bccf_pkg::FLAG_REG_ADDR[ADDR_W-1:0];
	assign wr_done = PSEL & PENABLE & s_q.ack & PWRITE;
	assign rd_done = PSEL & PENABLE & s_q.ack & ~PWRITE;
	assign is_cmp = OP_EXEC & ((OP_KIND == bccf_pkg::OP_MSG_CMP) |
		(OP_KIND == bccf_pkg::OP_FRAME_CMP));

	// condition test; result codes 8..15 come from the message logic
	assign COND_MET = codes[OP_COND[3:0]] ^ OP_COND[bccf_pkg::COND_INVERT_POS];

	// apb answer: one wait state so read data comes from a flip-flop
	assign PREADY = PSEL & PENABLE & s_q.ack;
	assign PSLVERR = PREADY & s_q.err;
	assign PRDATA = {16'h0000, s_q.rdata};
	assign GP_FLAGS = s_q.flags;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		s_d.ack = PSEL & PENABLE & ~s_q.ack;
		if (PSEL & PENABLE & ~s_q.ack) begin
			s_d.err = ~hit;
			// read-only view of all sixteen codes
			s_d.rdata = (hit & ~PWRITE) ? codes : bccf_pkg::RDATA_RESET;
		end
		// host write lands first so that an instruction in the same cycle wins
		if (wr_done & ~s_q.err) begin
			s_d.flags = bccf_pkg::bccf_apply(s_d.flags, PWDATA[15:0]);
		end
		if (OP_EXEC & (OP_KIND == bccf_pkg::OP_FLAG_UPD)) begin
			s_d.flags = bccf_pkg::bccf_apply(s_d.flags, OP_PARAM);
		end
		// both compare flags move in one cycle; flags two-seven untouched
		if (is_cmp) begin
			s_d.flags[bccf_pkg::LESS_FLAG_POS] = cmp_if.less;
			s_d.flags[bccf_pkg::EQUAL_FLAG_POS] = cmp_if.equal;
		end
		if (rd_done) begin
			s_d.rdata = bccf_pkg::RDATA_RESET;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_q <= '{flags: bccf_pkg::FLAGS_RESET, rdata: bccf_pkg::RDATA_RESET,
				ack: 1'b0, err: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_msg_equal;
		OP_EXEC && OP_KIND == bccf_pkg::OP_MSG_CMP && OP_PARAM == MSG_TIMER |=> GP_FLAGS[1];
	endproperty
	a_msg_equal: assert property (p_msg_equal) else $error("message compare equal left flag one low");

	property p_frame_unequal;
		OP_EXEC && OP_KIND == bccf_pkg::OP_FRAME_CMP && OP_PARAM != FRAME_TIMER |=> !GP_FLAGS[1];
	endproperty
	a_frame_unequal: assert property (p_frame_unequal) else $error("frame compare unequal left flag one high");

	property p_less_set;
		is_cmp && OP_PARAM < cmp_if.counter |=> GP_FLAGS[0];
	endproperty
	a_less_set: assert property (p_less_set) else $error("less flag not set below counter");

	property p_less_order;
		is_cmp && OP_PARAM > cmp_if.counter |=> !GP_FLAGS[0] && !GP_FLAGS[1];
	endproperty
	a_less_order: assert property (p_less_order) else $error("greater compare gave wrong flags");

	property p_pair;
		is_cmp |=> GP_FLAGS[1:0] == {$past(OP_PARAM == cmp_if.counter), $past(OP_PARAM < cmp_if.counter)};
	endproperty
	a_pair: assert property (p_pair) else $error("flags zero and one not updated together");

	property p_high_kept;
		is_cmp && !wr_done |=> GP_FLAGS[7:2] == $past(GP_FLAGS[7:2]);
	endproperty
	a_high_kept: assert property (p_high_kept) else $error("compare changed flags two to seven");

	property p_host_set;
		wr_done && hit && PWDATA[15:8] == 8'h00 && !OP_EXEC |=> (GP_FLAGS & $past(PWDATA[7:0])) == $past(PWDATA[7:0]);
	endproperty
	a_host_set: assert property (p_host_set) else $error("host set did not reach the flags");

	property p_upd_toggle;
		OP_EXEC && OP_KIND == bccf_pkg::OP_FLAG_UPD && OP_PARAM == 16'hFFFF && !wr_done
			|=> GP_FLAGS == ~$past(GP_FLAGS);
	endproperty
	a_upd_toggle: assert property (p_upd_toggle) else $error("flag update toggle failed");

	property p_read_codes;
		PSEL && PENABLE && !PWRITE && hit && !s_q.ack ##1 PREADY |-> PRDATA[15:0] == $past(codes);
	endproperty
	a_read_codes: assert property (p_read_codes) else $error("read did not return the sixteen codes");

	property p_cond;
		OP_COND == 5'h11 |-> COND_MET == !GP_FLAGS[1];
	endproperty
	a_cond: assert property (p_cond) else $error("not-equal test wrong");

endmodule

// [bc_condition_flag_logic_tb.sv]
// self-checking bench of the condition flag block, random ops with timer corner cases
// assumes the apb slave answers by pready and instructions are single-cycle pulses
`timescale 1ns/1ps
module bc_condition_flag_logic_tb;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, exec = 0, ok;
	logic [11:0] paddr = 0, a;
	logic [31:0] pwdata = 0, prdata, rd, err;
	logic pready, pslverr, cond_met;
	bccf_pkg::bccf_op_t kind = bccf_pkg::OP_OTHER;
	logic [15:0] param = 0, mt = 0, ft = 0, c, p, e;
	logic [4:0] cond = 0;
	logic [7:0] res = 0, flags, m = 0;
	int n_mismatch = 0, n_tests = 0, k, j;

	bccf_flags i_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OP_EXEC(exec),
		.OP_KIND(kind), .OP_PARAM(param), .OP_COND(cond), .MSG_TIMER(mt), .FRAME_TIMER(ft),
		.MSG_RESULT(res), .COND_MET(cond_met), .GP_FLAGS(flags));

	// 25 MHz clock
	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////////////////
	// expected flag byte: set low byte, clear high byte, both bits together toggle
	function automatic logic [7:0] upd(input logic [7:0] f, input logic [15:0] w);
		return ((f & ~w[15:8]) | w[7:0]) ^ (w[7:0] & w[15:8] & f);
	endfunction

	// counts every comparison, reports a mismatch at once
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer, entered just after an edge; bounded wait so a dead slave cannot hang
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int i;
		psel <= 1;
		pwr <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		// look at pready once settled, so the value seen is the one the next edge samples
		#1;
		for (i = 0; i < 20 && pready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk(i, 1);
		rd = prdata;
		err = pslverr;
		// completion edge: request still standing here, released only after it
		@(posedge clk);
		if (w && ad == bccf_pkg::FLAG_REG_ADDR) m = upd(m, d[15:0]);
		psel <= 0;
		pen <= 0;
	endtask

	// one instruction pulse; compare touches only flags zero and one
	task automatic op(input bccf_pkg::bccf_op_t kd, input logic [15:0] pv);
		exec <= 1;
		kind <= kd;
		param <= pv;
		@(posedge clk);
		exec <= 0;
		c = (kd == bccf_pkg::OP_FRAME_CMP) ? ft : mt;
		if (kd == bccf_pkg::OP_FLAG_UPD) m = upd(m, pv);
		if (kd == bccf_pkg::OP_MSG_CMP || kd == bccf_pkg::OP_FRAME_CMP) m[1:0] = {pv == c, pv < c};
	endtask

	task automatic end_sim;
		if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////////////////
	// watchdog at 10000 cycles, far beyond the at most about 1500 cycles the run needs
	initial begin
		#(40 * 10000);
		n_mismatch++;
		end_sim();
	end

	// main sequence: each op picks at random a parameter equal to, one below or one above the timer, or a plain random value
	initial begin
		k = $urandom(1);
		repeat (6) @(posedge clk);
		rst <= 0;
		#1 chk(flags, 0);
		for (int n = 0; n < 300; n++) begin
			@(posedge clk);
			mt <= 16'($urandom);
			ft <= 16'($urandom);
			res <= 8'($urandom);
			cond <= 5'($urandom);
			@(posedge clk);
			k = $urandom % 8;
			j = $urandom % 6;
			c = (j == 2) ? ft : mt;
			p = (k < 2) ? c : (k < 4) ? c - 16'h0001 : (k < 6) ? c + 16'h0001 : 16'($urandom);
			a = k[2] ? bccf_pkg::FLAG_REG_ADDR : 12'(bccf_pkg::FLAG_REG_ADDR ^ (12'h004 << k[1:0]));
			ok = (a == bccf_pkg::FLAG_REG_ADDR);
			if (j < 4) op(bccf_pkg::bccf_op_t'(j[1:0]), p);
			else apb(j == 4, a, $urandom);
			e = {res, m};
			#1 chk(flags, m);
			chk(cond_met, e[cond[3:0]] ^ cond[4]);
			if (j >= 4) chk(err, !ok);
			if (j == 5) chk(rd, ok ? {16'h0000, e} : 32'h0000_0000);
		end
		// second reset after the random ops clears the flags again
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		m = 8'h00;
		#1 chk(flags, m);
		end_sim();
	end
endmodule
